// [isp_port_defines.vh]
/*
 * constants for the serial test port enable block: register offset, field
 * positions, reset values, instruction codes and timing counts.
 * assumes inclusion by bare name from the design files of this block.
 */
`ifndef ISP_PORT_DEFINES_VH
`define ISP_PORT_DEFINES_VH

// register map, offset from io_register_base
`define TEST_PORT_ENABLE_OFS   8'hc7
`define TEST_PORT_ENABLE_BIT   0
`define TEST_PORT_ENABLE_RST   8'h00

// instruction register
`define IR_WIDTH               4
`define IR_RESET_VAL           4'h1
`define INS_ENABLE             4'h2
`define INS_ENABLE_EXT         4'h3
`define INS_CONFIG_OD          4'h4
`define INS_CLEAR_ERR          4'h5
`define INS_DISABLE            4'h6
`define INS_PROGRAM            4'h7
`define INS_SECTOR_ERASE       4'h8
`define INS_VERIFY             4'h9
`define INS_READ               4'ha
`define INS_CHIP_ERASE         4'hb
`define INS_BYPASS             4'hf

// data register: [15] secondary array, [14:12] sector, [11:0] spare
`define DR_WIDTH               16
`define DR_ARRAY_BIT           15
`define DR_SECT_HI             14
`define DR_SECT_LO             12

// sector counts: 8 primary, 4 secondary
`define PRI_SECTORS            8
`define SEC_SECTORS            4

// flash abort recovery, 25 us at 40 MHz, least time rounds up
`define ABORT_RECOVERY_NS      25000
`define CLK_PERIOD_NS          25
`define ABORT_CYCLES           ((`ABORT_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [tap_fsm.v]
/*
 * serial test access controller state machine, stepped by a one-cycle
 * enable marking a rising edge of the test clock.
 * assumes tms_in is stable in the cycle that step_in is high.
 */
`timescale 1ns/1ps
`default_nettype none

module tap_fsm (
    // clock and reset
    input  wire       mclk_in,
    input  wire       nrst_in,
    // control
    input  wire       clear_in,
    input  wire       step_in,
    input  wire       tms_in,
    // state
    output reg  [3:0] state_out
);

    localparam TLR = 4'h0, RTI = 4'h1, SDR = 4'h2, CDR = 4'h3;
    localparam SHDR = 4'h4, E1DR = 4'h5, PDR = 4'h6, E2DR = 4'h7;
    localparam UDR = 4'h8, SIR = 4'h9, CIR = 4'ha, SHIR = 4'hb;
    localparam E1IR = 4'hc, PIR = 4'hd, E2IR = 4'he, UIR = 4'hf;

    reg [3:0] state_nxt;

    always @* begin
        case (state_out)
            TLR:     state_nxt = tms_in ? TLR : RTI;
            RTI:     state_nxt = tms_in ? SDR : RTI;
            SDR:     state_nxt = tms_in ? SIR : CDR;
            CDR:     state_nxt = tms_in ? E1DR : SHDR;
            SHDR:    state_nxt = tms_in ? E1DR : SHDR;
            E1DR:    state_nxt = tms_in ? UDR : PDR;
            PDR:     state_nxt = tms_in ? E2DR : PDR;
            E2DR:    state_nxt = tms_in ? UDR : SHDR;
            UDR:     state_nxt = tms_in ? SDR : RTI;
            SIR:     state_nxt = tms_in ? TLR : CIR;
            CIR:     state_nxt = tms_in ? E1IR : SHIR;
            SHIR:    state_nxt = tms_in ? E1IR : SHIR;
            E1IR:    state_nxt = tms_in ? UIR : PIR;
            PIR:     state_nxt = tms_in ? E2IR : PIR;
            E2IR:    state_nxt = tms_in ? UIR : SHIR;
            UIR:     state_nxt = tms_in ? SDR : RTI;
            default: state_nxt = TLR;
        endcase
    end

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_out <= TLR;
        end else if (clear_in) begin
            state_out <= TLR;
        end else if (step_in) begin
            state_out <= state_nxt;
        end
    end

endmodule

`default_nettype wire

// [jtag_isp_port_enable.v]
/*
 * in-system-programming serial test port of a memory and logic peripheral:
 * pin dedication, channel activation, extension pins, security lock,
 * sector protection and flash command issue.
 * assumes a separate flash engine answers busy/fail and a port block muxes
 * the pins using the dedicate and drive outputs of this block.
 */
// Summary of operation
// - pins dedicated when nonvolatile bit, runtime bit or product term is true
// - test pins stay inputs until enabling command; only then drive TDO
// - enabling command may also turn on the two extension pins
// - with no condition true, pins return to general-purpose I/O
// - blank device enables basic pins; TMS,TCK,TDI,TDO on bits 0..3
// - ready status on pin 4, error flag on pin 5, command enabled
// - runtime enable register at offset c7 writable by host
// - runtime enable bit cleared by device reset or host write
// - reserved product term enables pins, allowing multiplexing
// - with nonvolatile dedication, device reset does not disturb port
// - with runtime-only enable, device reset prevents or aborts port
// - only programming instructions, no boundary scan
// - error flag low on erase or program failure, held until cleared
// - error cleared by clear command or reset after disable command
// - ready status high while both arrays in read mode
// - ready status low during program, erase or secondary write
// - configuration command makes extension pins open drain
// - security bit refuses all content read-out
// - security bit blocks all flash commands except full-chip erase
// - full-chip erase clears security, device becomes blank
// - each sector has protect bit; erase to protected sector refused
// - device reset aborts flash cycle, read mode after recovery time
`timescale 1ns/1ps
`default_nettype none
`include "isp_port_defines.vh"

module jtag_isp_port_enable (
    // clock and reset
    input  wire        mclk_in,
    input  wire        nrst_in,
    // device reset and configuration
    input  wire        dev_reset_in,
    input  wire        nvm_dedicate_in,
    input  wire        blank_in,
    input  wire        security_in,
    input  wire [11:0] sector_protect_in,
    input  wire        test_select_term_in,
    // register access via io_register_base
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // port pins 0..5
    input  wire [5:0]  port_pin_in,
    output wire [5:0]  port_pin_out,
    output wire [5:0]  port_pin_oe_out,
    output wire        pins_dedicated_out,
    // flash engine
    input  wire        flash_busy_in,
    input  wire        flash_fail_in,
    input  wire        sec_writing_in,
    output reg         flash_cmd_out,
    output reg  [3:0]  flash_op_out,
    output reg  [15:0] flash_arg_out,
    output reg         flash_abort_out,
    output reg         security_clear_out
);

    reg  [7:0]  enable_reg_r;
    reg  [2:0]  tck_sync_r, tms_sync_r, tdi_sync_r;
    reg         tck_level_r, tms_level_r, tdi_level_r;
    reg         active_r, ext_en_r, open_drain_r, err_n_r, disabled_r;
    reg  [3:0]  ir_shift_r, ir_r;
    reg  [15:0] dr_shift_r;
    reg         bypass_r, tdo_r;
    reg  [9:0]  abort_cnt_r;
    reg         dev_reset_d_r;
    wire [3:0]  tap_state;
    wire        runtime_en, dedicate, tck_rise, tck_fall, port_hold;
    wire        sect_protected, ready, op_allowed;
    wire [3:0]  sect_index;

    localparam TLR = 4'h0, CDR = 4'h3, SHDR = 4'h4, UDR = 4'h8;
    localparam CIR = 4'ha, SHIR = 4'hb, UIR = 4'hf;
    localparam [31:0] ABORT_LOAD = `ABORT_CYCLES - 1;

    assign runtime_en = enable_reg_r[`TEST_PORT_ENABLE_BIT];
    assign dedicate = nvm_dedicate_in | blank_in | runtime_en | test_select_term_in;
    assign pins_dedicated_out = dedicate;
    assign port_hold = dev_reset_in & ~(nvm_dedicate_in | blank_in);

    // host register, cleared by device reset or host write
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_reg_r <= `TEST_PORT_ENABLE_RST;
        end else if (dev_reset_in) begin
            enable_reg_r <= `TEST_PORT_ENABLE_RST;
        end else if (reg_wr_in && reg_addr_in == `TEST_PORT_ENABLE_OFS) begin
            enable_reg_r <= reg_wdata_in;
        end
    end

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in && reg_addr_in == `TEST_PORT_ENABLE_OFS) begin
            reg_rdata_out <= enable_reg_r;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // pin synchronisers: a change counts when stages two and three agree
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tck_sync_r  <= 3'b000;
            tms_sync_r  <= 3'b111;
            tdi_sync_r  <= 3'b000;
            tck_level_r <= 1'b0;
            tms_level_r <= 1'b1;
            tdi_level_r <= 1'b0;
        end else begin
            tck_sync_r <= {tck_sync_r[1:0], port_pin_in[1]};
            tms_sync_r <= {tms_sync_r[1:0], port_pin_in[0]};
            tdi_sync_r <= {tdi_sync_r[1:0], port_pin_in[2]};
            if (tck_sync_r[1] == tck_sync_r[2]) tck_level_r <= tck_sync_r[2];
            if (tms_sync_r[1] == tms_sync_r[2]) tms_level_r <= tms_sync_r[2];
            if (tdi_sync_r[1] == tdi_sync_r[2]) tdi_level_r <= tdi_sync_r[2];
        end
    end

    assign tck_rise = dedicate & (tck_sync_r[1] == tck_sync_r[2]) & tck_sync_r[2] & ~tck_level_r;
    assign tck_fall = dedicate & (tck_sync_r[1] == tck_sync_r[2]) & ~tck_sync_r[2] & tck_level_r;

    tap_fsm u_tap (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .clear_in  (~dedicate | port_hold),
        .step_in   (tck_rise),
        .tms_in    (tms_level_r),
        .state_out (tap_state)
    );

    assign sect_index = dr_shift_r[`DR_ARRAY_BIT] ?
                        {2'b10, dr_shift_r[`DR_SECT_LO+1:`DR_SECT_LO]} :
                        {1'b0, dr_shift_r[`DR_SECT_HI:`DR_SECT_LO]};
    assign sect_protected = sector_protect_in[sect_index];
    assign op_allowed = active_r & (~security_in | ir_r == `INS_CHIP_ERASE);
    assign ready = ~flash_busy_in & ~sec_writing_in & ~flash_abort_out;

    // shift paths and instruction handling on test clock edges
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ir_shift_r <= `IR_RESET_VAL;
            ir_r       <= `IR_RESET_VAL;
            dr_shift_r <= 16'h0000;
            bypass_r   <= 1'b0;
            active_r   <= 1'b0;
            ext_en_r   <= 1'b0;
            open_drain_r <= 1'b0;
            disabled_r <= 1'b0;
            tdo_r      <= 1'b0;
            flash_cmd_out <= 1'b0;
            flash_op_out  <= 4'h0;
            flash_arg_out <= 16'h0000;
            security_clear_out <= 1'b0;
        end else begin
            flash_cmd_out      <= 1'b0;
            security_clear_out <= 1'b0;
            if (~dedicate | port_hold) begin
                ir_r     <= `IR_RESET_VAL;
                active_r <= 1'b0;
                ext_en_r <= 1'b0;
                open_drain_r <= 1'b0;
            end else if (tck_rise) begin
                case (tap_state)
                    TLR: begin
                        ir_r <= `IR_RESET_VAL;
                    end
                    CIR: begin
                        ir_shift_r <= `IR_RESET_VAL;
                    end
                    SHIR: begin
                        ir_shift_r <= {tdi_level_r, ir_shift_r[3:1]};
                    end
                    CDR: begin
                        if (ir_r == `INS_READ && active_r && !security_in)
                            dr_shift_r <= flash_arg_out;
                        else
                            dr_shift_r <= {14'h0000, ~err_n_r, ready};
                        bypass_r <= 1'b0;
                    end
                    SHDR: begin
                        dr_shift_r <= {tdi_level_r, dr_shift_r[15:1]};
                        bypass_r   <= tdi_level_r;
                    end
                    UIR: begin
                        ir_r <= ir_shift_r;
                        if (ir_shift_r == `INS_ENABLE) begin
                            active_r <= 1'b1;
                            disabled_r <= 1'b0;
                        end
                        if (ir_shift_r == `INS_ENABLE_EXT) begin
                            active_r <= 1'b1;
                            ext_en_r <= 1'b1;
                            disabled_r <= 1'b0;
                        end
                        if (ir_shift_r == `INS_CONFIG_OD && active_r)
                            open_drain_r <= 1'b1;
                        if (ir_shift_r == `INS_DISABLE && active_r) begin
                            active_r   <= 1'b0;
                            ext_en_r   <= 1'b0;
                            disabled_r <= 1'b1;
                        end
                    end
                    UDR: begin
                        if (op_allowed) begin
                            case (ir_r)
                                `INS_PROGRAM, `INS_VERIFY: begin
                                    flash_cmd_out <= 1'b1;
                                    flash_op_out  <= ir_r;
                                    flash_arg_out <= dr_shift_r;
                                end
                                `INS_SECTOR_ERASE: begin
                                    if (!sect_protected) begin
                                        flash_cmd_out <= 1'b1;
                                        flash_op_out  <= ir_r;
                                        flash_arg_out <= dr_shift_r;
                                    end
                                end
                                `INS_CHIP_ERASE: begin
                                    flash_cmd_out <= 1'b1;
                                    flash_op_out  <= ir_r;
                                    security_clear_out <= 1'b1;
                                end
                                default: begin
                                    flash_op_out <= flash_op_out;
                                end
                            endcase
                        end
                    end
                    default: begin
                        bypass_r <= bypass_r;
                    end
                endcase
            end else if (tck_fall) begin
                tdo_r <= (tap_state == SHIR) ? ir_shift_r[0] :
                         (ir_r == `INS_BYPASS) ? bypass_r : dr_shift_r[0];
            end
        end
    end

    // sticky active-low error flag
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_n_r <= 1'b1;
        end else if (flash_fail_in) begin
            err_n_r <= 1'b0; // set wins over clear
        end else if (dedicate && tck_rise && tap_state == UIR && active_r &&
                     ir_shift_r == `INS_CLEAR_ERR) begin
            err_n_r <= 1'b1;
        end else if (dev_reset_in && disabled_r) begin
            err_n_r <= 1'b1;
        end
    end

    // device reset aborts flash cycle for the recovery period
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dev_reset_d_r   <= 1'b0;
            abort_cnt_r     <= 10'h000;
            flash_abort_out <= 1'b0;
        end else begin
            dev_reset_d_r <= dev_reset_in;
            if (dev_reset_in && !dev_reset_d_r) begin
                abort_cnt_r     <= ABORT_LOAD[9:0];
                flash_abort_out <= 1'b1;
            end else if (abort_cnt_r != 10'h000) begin
                abort_cnt_r <= abort_cnt_r - 10'h001;
            end else begin
                flash_abort_out <= 1'b0;
            end
        end
    end

    // pin drive: bits 0..2 inputs, 3 TDO, 4 ready, 5 error
    assign port_pin_out[2:0]    = 3'b000;
    assign port_pin_oe_out[2:0] = 3'b000;
    assign port_pin_out[3]      = tdo_r;
    assign port_pin_oe_out[3]   = dedicate & active_r & ~port_hold;
    assign port_pin_out[4]      = open_drain_r ? 1'b0 : ready;
    assign port_pin_oe_out[4]   = dedicate & ext_en_r & (open_drain_r ? ~ready : 1'b1);
    assign port_pin_out[5]      = open_drain_r ? 1'b0 : err_n_r;
    assign port_pin_oe_out[5]   = dedicate & ext_en_r & (open_drain_r ? ~err_n_r : 1'b1);

endmodule

`default_nettype wire

// [jtag_isp_port_enable_asserts.sv]
/*
 * concurrent checks on the ports of the serial test port enable block.
 * assumes the block's defines header and one clock domain on mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isp_port_defines.vh"
module jtag_isp_port_enable_asserts (
    // clock, reset and configuration
    input wire logic        mclk_in,
    input wire logic        nrst_in,
    input wire logic        dev_reset_in,
    input wire logic        nvm_dedicate_in,
    input wire logic        blank_in,
    input wire logic        security_in,
    input wire logic [11:0] sector_protect_in,
    input wire logic        test_select_term_in,
    // register read
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    // pins
    input wire logic [5:0]  port_pin_out,
    input wire logic [5:0]  port_pin_oe_out,
    input wire logic        pins_dedicated_out,
    // flash engine
    input wire logic        flash_busy_in,
    input wire logic        flash_fail_in,
    input wire logic        sec_writing_in,
    input wire logic        flash_cmd_out,
    input wire logic [3:0]  flash_op_out,
    input wire logic [15:0] flash_arg_out,
    input wire logic        flash_abort_out,
    input wire logic        security_clear_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_busy;
        (flash_busy_in || sec_writing_in)[*3];
    endsequence
    sequence s_idle;
        (!flash_busy_in && !sec_writing_in && !flash_abort_out)[*3];
    endsequence
    a_dedicate_or: assert property ((nvm_dedicate_in || blank_in || test_select_term_in) |-> pins_dedicated_out) else $error("pins not dedicated");
    a_release_gpio: assert property (!pins_dedicated_out |-> port_pin_oe_out == 6'h00) else $error("pins driven while released");
    a_inputs_only: assert property (port_pin_oe_out[2:0] == 3'h0) else $error("input pin driven");
    a_ext_after_tdo: assert property (|port_pin_oe_out[5:4] |-> port_pin_oe_out[3]) else $error("extension pin without channel");
    a_busy_low: assert property (s_busy ##0 port_pin_oe_out[4] |-> !port_pin_out[4]) else $error("ready high while busy");
    a_ready_high: assert property (s_idle ##0 port_pin_oe_out[4] |-> port_pin_out[4]) else $error("ready low while idle");
    a_err_latch: assert property (flash_fail_in && port_pin_oe_out[5] |-> ##[1:2] (port_pin_oe_out[5] && !port_pin_out[5])) else $error("error flag not low");
    a_secure_block: assert property (security_in[*4] ##0 flash_cmd_out |-> flash_op_out == `INS_CHIP_ERASE) else $error("command passed while secured");
    a_clear_on_erase: assert property (security_clear_out |-> flash_cmd_out && flash_op_out == `INS_CHIP_ERASE) else $error("security clear without erase");
    a_protect_erase: assert property (flash_cmd_out && flash_op_out == `INS_SECTOR_ERASE |-> !(flash_arg_out[15] ? sector_protect_in[{2'h2, flash_arg_out[13:12]}] : sector_protect_in[{1'h0, flash_arg_out[14:12]}])) else $error("protected sector erased");
    a_abort_start: assert property ($rose(dev_reset_in) |-> ##[1:2] flash_abort_out) else $error("no flash abort");
    a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("read data without strobe");
endmodule
bind jtag_isp_port_enable jtag_isp_port_enable_asserts jtag_isp_port_enable_asserts_inst (.*);
`default_nettype wire

// [test_controller_model.sv]
/*
 * external serial test controller: steps the test clock from the system clock.
 * assumes the caller enters a task just after a system clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module test_controller_model (
    // clock
    input  wire logic mclk_in,
    // serial test lines
    output var  logic tck_out,
    output var  logic tms_out,
    output var  logic tdi_out,
    input  wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one 8-cycle test clock period; tdo taken at the end of the high phase
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge mclk_in);
        tck_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        tdo = tdo_in;
        tck_out <= 1'b0;
    endtask
    task automatic shift(input logic [15:0] v, input int n, output logic [15:0] cap);
        logic b;
        cap = 16'h0000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], b);
            cap[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    task automatic reset_tap();
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    task automatic shift_ir(input logic [3:0] code);
        logic        b;
        logic [15:0] c;
        step(1'b1, 1'b0, b);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        shift({12'h000, code}, 4, c);
    endtask
    task automatic shift_dr(input logic [15:0] v, output logic [15:0] cap);
        logic b;
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        shift(v, 16, cap);
    endtask
endmodule
`default_nettype wire

// [jtag_isp_port_enable_bench.sv]
/*
 * testbench for the serial test port enable block: register access, pin
 * dedication, channel commands, extension pins, protection and security.
 * assumes the controller model and the checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isp_port_defines.vh"
module jtag_isp_port_enable_bench;
    logic mclk_in = 1'b0, nrst_in = 1'b0, dev_reset_in = 1'b0, nvm_dedicate_in = 1'b0;
    logic blank_in = 1'b0, security_in = 1'b0, test_select_term_in = 1'b0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, flash_busy_in = 1'b0;
    logic flash_fail_in = 1'b0, sec_writing_in = 1'b0;
    logic [11:0] sector_protect_in = 12'h204;
    logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    wire  [7:0]  reg_rdata_out;
    wire  [5:0]  port_pin_out, port_pin_oe_out, pin_lvl;
    wire  [3:0]  flash_op_out;
    wire  [15:0] flash_arg_out;
    wire  pins_dedicated_out, flash_cmd_out, flash_abort_out, security_clear_out;
    wire  tck, tms, tdi;
    int   n_fail = 0, compares = 0, n_cmd = 0, n_clr = 0;
    logic [15:0] last_op, last_arg, d;
    logic [3:0]  refused [4] = '{`INS_PROGRAM, `INS_SECTOR_ERASE, `INS_VERIFY, `INS_READ};
    always #12.5 mclk_in = ~mclk_in;
    // pins 3..5 carry pull-ups when released
    assign pin_lvl = (port_pin_oe_out & port_pin_out) | ~port_pin_oe_out;
    jtag_isp_port_enable jtag_isp_port_enable_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .dev_reset_in(dev_reset_in), .nvm_dedicate_in(nvm_dedicate_in), .blank_in(blank_in),
        .security_in(security_in), .sector_protect_in(sector_protect_in),
        .test_select_term_in(test_select_term_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .port_pin_in({pin_lvl[5:3], tdi, tck, tms}),
        .port_pin_out(port_pin_out), .port_pin_oe_out(port_pin_oe_out),
        .pins_dedicated_out(pins_dedicated_out), .flash_busy_in(flash_busy_in),
        .flash_fail_in(flash_fail_in), .sec_writing_in(sec_writing_in),
        .flash_cmd_out(flash_cmd_out), .flash_op_out(flash_op_out),
        .flash_arg_out(flash_arg_out), .flash_abort_out(flash_abort_out),
        .security_clear_out(security_clear_out));
    test_controller_model test_controller_model_inst (.mclk_in(mclk_in), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi), .tdo_in(pin_lvl[3]));
    always @(posedge mclk_in) begin
        if (flash_cmd_out === 1'b1) begin
            n_cmd <= n_cmd + 1;
            last_op <= {12'h000, flash_op_out};
            last_arg <= flash_arg_out;
        end
        if (security_clear_out === 1'b1) n_clr <= n_clr + 1;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 v = {8'h00, reg_rdata_out};
        @(posedge mclk_in);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        wait_cyc(40000);
        n_fail = n_fail + 1;
        tally_and_finish();
    end
    initial begin
        wait_cyc(6);
        nrst_in <= 1'b1;
        wait_cyc(2);
        cmp(pins_dedicated_out, 1'b0);
        cmp(port_pin_oe_out, 6'h00);
        reg_read(`TEST_PORT_ENABLE_OFS, d); cmp(d, `TEST_PORT_ENABLE_RST);
        reg_write(`TEST_PORT_ENABLE_OFS, 8'h01);
        reg_read(`TEST_PORT_ENABLE_OFS, d); cmp(d, 8'h01);
        cmp(pins_dedicated_out, 1'b1);
        cmp(port_pin_oe_out[3], 1'b0);
        reg_write(`TEST_PORT_ENABLE_OFS, 8'h00);
        reg_read(`TEST_PORT_ENABLE_OFS, d); cmp(d, 8'h00);
        reg_read(8'h10, d); cmp(d, 8'h00);
        // one dedicate source at a time
        for (int i = 0; i < 3; i++) begin
            {test_select_term_in, blank_in, nvm_dedicate_in} <= 3'h1 << i;
            wait_cyc(2);
            cmp(pins_dedicated_out, 1'b1);
        end
        {test_select_term_in, blank_in, nvm_dedicate_in} <= 3'h1;
        test_controller_model_inst.reset_tap();
        test_controller_model_inst.shift_ir(`INS_ENABLE);
        wait_cyc(8); cmp(port_pin_oe_out[5:3], 3'h1);
        test_controller_model_inst.shift_ir(`INS_ENABLE_EXT);
        wait_cyc(8); cmp(port_pin_oe_out, 6'h38);
        cmp(port_pin_out[5:4], 2'h3);
        flash_busy_in <= 1'b1; wait_cyc(4); cmp(port_pin_out[4], 1'b0);
        flash_busy_in <= 1'b0; sec_writing_in <= 1'b1;
        wait_cyc(4); cmp(port_pin_out[4], 1'b0);
        sec_writing_in <= 1'b0;
        test_controller_model_inst.shift_ir(`INS_PROGRAM);
        test_controller_model_inst.shift_dr(16'h1234, d); cmp(d, 16'h0001);
        wait_cyc(4); cmp(n_cmd, 1); cmp(last_op, `INS_PROGRAM);
        cmp(last_arg, 16'h1234);
        flash_fail_in <= 1'b1; wait_cyc(1); flash_fail_in <= 1'b0;
        wait_cyc(20); cmp({port_pin_oe_out[5], port_pin_out[5]}, 2'h2);
        test_controller_model_inst.shift_ir(`INS_CLEAR_ERR);
        wait_cyc(8); cmp(port_pin_out[5], 1'b1);
        // protected primary sector 2 and secondary sector 1, then free sector 3
        test_controller_model_inst.shift_ir(`INS_SECTOR_ERASE);
        test_controller_model_inst.shift_dr(16'h2000, d);
        test_controller_model_inst.shift_dr(16'h9000, d);
        wait_cyc(4); cmp(n_cmd, 1);
        test_controller_model_inst.shift_dr(16'h3000, d);
        wait_cyc(4); cmp(n_cmd, 2); cmp(last_arg, 16'h3000);
        test_controller_model_inst.shift_ir(`INS_CONFIG_OD);
        wait_cyc(8); cmp(port_pin_oe_out[4], 1'b0);
        flash_busy_in <= 1'b1;
        wait_cyc(4); cmp({port_pin_oe_out[4], port_pin_out[4]}, 2'h2);
        flash_busy_in <= 1'b0;
        security_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            test_controller_model_inst.shift_ir(refused[i]);
            test_controller_model_inst.shift_dr(16'h3000, d); cmp(d, 16'h0001);
        end
        wait_cyc(4); cmp(n_cmd, 2);
        test_controller_model_inst.shift_ir(`INS_CHIP_ERASE);
        test_controller_model_inst.shift_dr(16'h0000, d);
        wait_cyc(4); cmp(last_op, `INS_CHIP_ERASE); cmp(n_clr, 1);
        security_in <= 1'b0;
        dev_reset_in <= 1'b1;
        wait_cyc(3); cmp(flash_abort_out, 1'b1);
        cmp(port_pin_oe_out[3], 1'b1);
        dev_reset_in <= 1'b0;
        wait_cyc(997); cmp(flash_abort_out, 1'b1); wait_cyc(3); cmp(flash_abort_out, 1'b0);
        reg_write(`TEST_PORT_ENABLE_OFS, 8'h01);
        nvm_dedicate_in <= 1'b0;
        test_controller_model_inst.shift_ir(`INS_ENABLE);
        wait_cyc(8); cmp(port_pin_oe_out[3], 1'b1);
        dev_reset_in <= 1'b1;
        wait_cyc(8); cmp(port_pin_oe_out[3], 1'b0);
        dev_reset_in <= 1'b0;
        reg_read(`TEST_PORT_ENABLE_OFS, d); cmp(d, 8'h00);
        cmp(pins_dedicated_out, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
